// ==== verilog/wdk_top.sv ====
// watchdog timer with keyed enable, keyed soft reset and reset-cause flags
// Function
// RULE1 - watchdog counts a low-speed oscillator tick near 32 kHz, divided by power of two
// RULE2 - select codes 0..7 give 2^8,10,12,14,15,16,17,18 tick time-outs
// RULE3 - enable key 10101B disables counting, 01010B enables it
// RULE4 - any other enable key resets after the soft delay and sets its fault flag
// RULE5 - power-on loads the enable key with 01010B so the watchdog runs
// RULE6 - overflow in normal run gives a full reset and sets the expiry flag
// RULE7 - overflow in sleep or idle sets expiry and clears only program counter and stack
// RULE8 - count clears on illegal enable key, clear instruction or stop instruction
// RULE9 - software must run the clear instruction often enough to avoid overflow
// RULE10 - enable key fault flag is bit 0, cleared only by software writing zero
// RULE11 - upper four bits of the reset cause flags always read zero
// RULE12 - reset key 01010101B or 10101010B does nothing, others reset after the delay
// RULE13 - power-on loads the reset key with 01010101B
// RULE14 - illegal reset key reset sets reset key fault flag, bit 3
// RULE15 - power-on clears the program counter to zero
// RULE16 - power-on presets all port data and control registers high
// RULE17 - stop instruction clears the count, counting resumes only when enabled
// RULE18 - power-down flag clears at power-up or clear instruction, sets on stop
// RULE19 - sleep or idle time-out reports expiry 1 and power-down 1
// RULE20 - count from zero, overflow at selected power of two, clears kept in step
// RULE21 - soft reset pulse comes only after a fixed delay from an illegal key
//
// Decided for this implementation: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ps
`include "wdk_params.svh"
module wdk_top (
    input  wire logic        sys_clk,          // system clock, 125 MHz
    input  wire logic        sys_rst,          // power-on reset, synchronous
    input  wire logic [3:0]  address,          // avalon byte address
    input  wire logic        read,             // avalon read
    input  wire logic        write,            // avalon write
    input  wire logic [31:0] writedata,        // avalon write data
    input  wire logic [3:0]  byteenable,       // avalon byte enables
    output logic [31:0]      readdata,         // avalon read data
    output logic             waitrequest,      // avalon wait
    input  wire logic        clear_wdt_instr,  // clear instruction executed
    input  wire logic        stop_instr,       // stop instruction executed
    input  wire logic        sleep_mode,       // core sleeping or idle
    output logic             device_reset,     // full device reset pulse
    output logic             pc_sp_reset,      // program counter and stack clear pulse
    output logic             pc_clear,         // program counter to zero
    output logic             port_preset,      // ports to all ones
    output logic             expiry_flag,      // watchdog expired
    output logic             powerdown_flag    // stop executed
);

    localparam int SR_LAT = `WDK_SRESET_CYC + 2;

    wdk_pkg::wdk_ctrl_t     watchdog_control;
    logic [7:0]             reset_key_reg;
    logic                   watchdog_key_fault_flag;
    logic                   reset_key_fault_flag;
    wdk_pkg::wdk_sr_state_t sr_state;
    logic [7:0]             sr_cnt;
    logic                   cause_w;
    logic                   cause_r;
    logic                   ack;
    logic [11:0]            div_cnt;
    logic                   lso_tick;
    logic                   wdt_ovf;
    logic [18:0]            wdt_count;

    // ---------------- register bus
    function automatic wdk_pkg::wdk_reg_t wdk_decode(input logic [3:0] a);
        if (a == `WDK_OFS_CTRL) begin
            wdk_decode = wdk_pkg::WDK_REG_CTRL;
        end else if (a == `WDK_OFS_FLAGS) begin
            wdk_decode = wdk_pkg::WDK_REG_FLAGS;
        end else if (a == `WDK_OFS_RKEY) begin
            wdk_decode = wdk_pkg::WDK_REG_RKEY;
        end else if (a == `WDK_OFS_STATUS) begin
            wdk_decode = wdk_pkg::WDK_REG_STATUS;
        end else begin
            wdk_decode = wdk_pkg::WDK_REG_NONE;
        end
    endfunction : wdk_decode

    logic              req;
    logic              wr_fire;
    wdk_pkg::wdk_reg_t reg_sel;

    assign req         = read || write;
    assign waitrequest = req && !ack;
    assign reg_sel     = wdk_decode(address);
    // writes land on the completing edge, only on byte lane 0
    assign wr_fire     = write && ack && byteenable[0];

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            ack <= 1'b0;
        end else begin
            ack <= req && !ack;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            readdata <= 32'h00000000;
        end else if (read && !ack) begin
            if (reg_sel == wdk_pkg::WDK_REG_CTRL) begin
                readdata <= {24'h000000, watchdog_control};
            end else if (reg_sel == wdk_pkg::WDK_REG_FLAGS) begin
                readdata <= {28'h0000000, reset_key_fault_flag, 2'b00,
                             watchdog_key_fault_flag}; // [RULE11]
            end else if (reg_sel == wdk_pkg::WDK_REG_RKEY) begin
                readdata <= {24'h000000, reset_key_reg};
            end else if (reg_sel == wdk_pkg::WDK_REG_STATUS) begin
                readdata <= {30'h00000000, powerdown_flag, expiry_flag};
            end else begin
                readdata <= 32'h00000000;
            end
        end
    end

    // ---------------- key checks and soft reset sequence
    logic wkey_bad;
    logic rkey_bad;
    logic wdt_run;
    logic soft_fire;
    logic full_rst;

    assign wdt_run  = watchdog_control.key == `WDK_KEY_EN; // [RULE3]
    assign wkey_bad = !wdt_run && (watchdog_control.key != `WDK_KEY_DIS); // [RULE4]
    assign rkey_bad = (reset_key_reg != `WDK_RKEY_OK_A)
                   && (reset_key_reg != `WDK_RKEY_OK_B); // [RULE12]
    assign soft_fire = sr_state == wdk_pkg::WDK_SR_FIRE;
    assign full_rst  = soft_fire || (wdt_ovf && !sleep_mode); // [RULE6]

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sr_state <= wdk_pkg::WDK_SR_IDLE;
            sr_cnt   <= 8'h00;
        end else begin
            case (sr_state)
                wdk_pkg::WDK_SR_IDLE: begin
                    sr_cnt <= 8'h00;
                    if (wkey_bad || rkey_bad) begin
                        sr_state <= wdk_pkg::WDK_SR_DELAY; // [RULE21]
                    end
                end
                wdk_pkg::WDK_SR_DELAY: begin
                    if (sr_cnt == 8'(`WDK_SRESET_CYC - 1)) begin
                        sr_state <= wdk_pkg::WDK_SR_FIRE; // [RULE21]
                    end else begin
                        sr_cnt <= sr_cnt + 8'h01;
                    end
                end
                default: begin
                    sr_state <= wdk_pkg::WDK_SR_IDLE;
                end
            endcase
        end
    end

    // causes are caught while the delay runs, so a key repaired mid-delay still counts
    always_ff @(posedge sys_clk) begin
        if (sys_rst || sr_state == wdk_pkg::WDK_SR_IDLE) begin
            cause_w <= wkey_bad;
            cause_r <= rkey_bad;
        end else if (sr_state == wdk_pkg::WDK_SR_DELAY) begin
            cause_w <= cause_w || wkey_bad;
            cause_r <= cause_r || rkey_bad;
        end
    end

    // ---------------- control registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst || full_rst) begin
            watchdog_control <= `WDK_CTRL_POR; // [RULE5]
        end else if (wr_fire && reg_sel == wdk_pkg::WDK_REG_CTRL) begin
            watchdog_control <= writedata[7:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst || full_rst) begin
            reset_key_reg <= `WDK_RKEY_POR; // [RULE13]
        end else if (wr_fire && reg_sel == wdk_pkg::WDK_REG_RKEY) begin
            reset_key_reg <= writedata[7:0];
        end
    end

    // fault flags survive soft resets; the set wins over a software clear
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            watchdog_key_fault_flag <= 1'b0;
        end else if (soft_fire && cause_w) begin
            watchdog_key_fault_flag <= 1'b1; // [RULE4] [RULE10]
        end else if (wr_fire && reg_sel == wdk_pkg::WDK_REG_FLAGS
                     && !writedata[`WDK_FLAG_WKF_BIT]) begin
            watchdog_key_fault_flag <= 1'b0; // [RULE10]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            reset_key_fault_flag <= 1'b0;
        end else if (soft_fire && cause_r) begin
            reset_key_fault_flag <= 1'b1; // [RULE14]
        end else if (wr_fire && reg_sel == wdk_pkg::WDK_REG_FLAGS
                     && !writedata[`WDK_FLAG_RKF_BIT]) begin
            reset_key_fault_flag <= 1'b0;
        end
    end

    // ---------------- low-speed tick and counter
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            div_cnt  <= 12'h000;
            lso_tick <= 1'b0;
        end else if (div_cnt == 12'(`WDK_LSO_DIV - 1)) begin
            div_cnt  <= 12'h000;
            lso_tick <= 1'b1; // [RULE1]
        end else begin
            div_cnt  <= div_cnt + 12'h001;
            lso_tick <= 1'b0;
        end
    end

    logic wdt_clear;
    // clears are on the same clock as the counter, so no crossing is needed
    assign wdt_clear = clear_wdt_instr || stop_instr || wkey_bad || full_rst; // [RULE8] [RULE17] [RULE20]

    wdk_counter u_counter (
        .sys_clk  (sys_clk),
        .sys_rst  (sys_rst),
        .tick     (lso_tick),
        .run      (wdt_run),
        .clear    (wdt_clear),
        .sel      (watchdog_control.sel),
        .overflow (wdt_ovf),
        .count    (wdt_count)
    );

    // ---------------- status flags
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            expiry_flag <= 1'b0;
        end else if (wdt_ovf) begin
            expiry_flag <= 1'b1; // [RULE6] [RULE7] [RULE19]
        end else if (clear_wdt_instr || stop_instr) begin
            expiry_flag <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            powerdown_flag <= 1'b0; // [RULE18]
        end else if (stop_instr) begin
            powerdown_flag <= 1'b1; // [RULE18] [RULE19]
        end else if (clear_wdt_instr) begin
            powerdown_flag <= 1'b0; // [RULE18]
        end
    end

    // ---------------- reset outputs
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            device_reset <= 1'b0;
            pc_sp_reset  <= 1'b0;
        end else begin
            device_reset <= full_rst; // [RULE4] [RULE6] [RULE12]
            pc_sp_reset  <= wdt_ovf && sleep_mode; // [RULE7]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            pc_clear    <= 1'b1; // [RULE15]
            port_preset <= 1'b1; // [RULE16]
        end else begin
            pc_clear    <= full_rst || (wdt_ovf && sleep_mode);
            port_preset <= full_rst;
        end
    end

    // ---------------- checks
    property p_ovf_expiry;
        @(posedge sys_clk) disable iff (sys_rst) wdt_ovf |=> expiry_flag;
    endproperty
    a_ovf_expiry: assert property (p_ovf_expiry) else $error("expiry not set"); // [RULE6]

    property p_run_ovf_reset;
        @(posedge sys_clk) disable iff (sys_rst)
            (wdt_ovf && !sleep_mode) |=> device_reset && !pc_sp_reset;
    endproperty
    a_run_ovf_reset: assert property (p_run_ovf_reset) else $error("no full reset"); // [RULE6]

    property p_sleep_ovf;
        @(posedge sys_clk) disable iff (sys_rst)
            (wdt_ovf && sleep_mode && !soft_fire) |=> pc_sp_reset && !device_reset && expiry_flag;
    endproperty
    a_sleep_ovf: assert property (p_sleep_ovf) else $error("bad sleep time-out"); // [RULE7]

    property p_soft_delay;
        @(posedge sys_clk) disable iff (sys_rst)
            (sr_state == wdk_pkg::WDK_SR_IDLE && (wkey_bad || rkey_bad)) |-> ##SR_LAT device_reset;
    endproperty
    a_soft_delay: assert property (p_soft_delay) else $error("soft reset late"); // [RULE21]

    property p_no_early_reset;
        @(posedge sys_clk) disable iff (sys_rst)
            (sr_state == wdk_pkg::WDK_SR_DELAY
             && sr_cnt != 8'(`WDK_SRESET_CYC - 1)) |=> !soft_fire;
    endproperty
    a_no_early_reset: assert property (p_no_early_reset) else $error("soft reset early"); // [RULE21]

    property p_wkf_set;
        @(posedge sys_clk) disable iff (sys_rst) (soft_fire && cause_w) |=> watchdog_key_fault_flag;
    endproperty
    a_wkf_set: assert property (p_wkf_set) else $error("key fault flag not set"); // [RULE10]

    property p_rkf_set;
        @(posedge sys_clk) disable iff (sys_rst) (soft_fire && cause_r) |=> reset_key_fault_flag;
    endproperty
    a_rkf_set: assert property (p_rkf_set) else $error("reset key flag not set"); // [RULE14]

    property p_stop_flags;
        @(posedge sys_clk) disable iff (sys_rst)
            (stop_instr && !wdt_ovf) |=> powerdown_flag && !expiry_flag;
    endproperty
    a_stop_flags: assert property (p_stop_flags) else $error("stop flags wrong"); // [RULE18]

    property p_clr_pd;
        @(posedge sys_clk) disable iff (sys_rst)
            (clear_wdt_instr && !stop_instr) |=> !powerdown_flag;
    endproperty
    a_clr_pd: assert property (p_clr_pd) else $error("power-down not cleared"); // [RULE18]

    property p_flags_upper;
        @(posedge sys_clk) disable iff (sys_rst)
            (read && ack && reg_sel == wdk_pkg::WDK_REG_FLAGS) |-> readdata[7:4] == 4'h0;
    endproperty
    a_flags_upper: assert property (p_flags_upper) else $error("upper flag bits set"); // [RULE11]

    property p_por_keys;
        @(posedge sys_clk) sys_rst |=> watchdog_control == `WDK_CTRL_POR
            && reset_key_reg == `WDK_RKEY_POR && pc_clear && port_preset;
    endproperty
    a_por_keys: assert property (p_por_keys) else $error("power-on state wrong"); // [RULE5]

    property p_rst_count;
        @(posedge sys_clk) disable iff (sys_rst) full_rst |=> wdt_count == 19'h00000;
    endproperty
    a_rst_count: assert property (p_rst_count) else $error("count kept"); // [RULE8]

endmodule : wdk_top

// ==== include/wdk_params.svh ====
// offsets, field positions, reset values and timing counts of the watchdog block
`ifndef WDK_PARAMS_SVH
`define WDK_PARAMS_SVH

`define WDK_CLK_HZ        125000000
`define WDK_CLK_NS        8
`define WDK_LSO_HZ        32000
`define WDK_LSO_DIV       (`WDK_CLK_HZ / `WDK_LSO_HZ)
`define WDK_SRESET_NS     128
`define WDK_SRESET_CYC    ((`WDK_SRESET_NS + `WDK_CLK_NS - 1) / `WDK_CLK_NS)

`define WDK_OFS_CTRL      4'h0
`define WDK_OFS_FLAGS     4'h4
`define WDK_OFS_RKEY      4'h8
`define WDK_OFS_STATUS    4'hc

`define WDK_CTRL_POR      8'h53
`define WDK_RKEY_POR      8'h55
`define WDK_KEY_DIS       5'h15
`define WDK_KEY_EN        5'h0a
`define WDK_RKEY_OK_A     8'h55
`define WDK_RKEY_OK_B     8'haa

`define WDK_FLAG_WKF_BIT  0
`define WDK_FLAG_RKF_BIT  3
`define WDK_STAT_EXP_BIT  0
`define WDK_STAT_PD_BIT   1

`endif

// ==== include/wdk_pkg.sv ====
// types shared by the watchdog block
package wdk_pkg;

    typedef struct packed {
        logic [4:0] key;
        logic [2:0] sel;
    } wdk_ctrl_t;

    typedef enum logic [1:0] {
        WDK_SR_IDLE  = 2'b00,
        WDK_SR_DELAY = 2'b01,
        WDK_SR_FIRE  = 2'b10
    } wdk_sr_state_t;

    typedef enum logic [2:0] {
        WDK_REG_NONE   = 3'b000,
        WDK_REG_CTRL   = 3'b001,
        WDK_REG_FLAGS  = 3'b010,
        WDK_REG_RKEY   = 3'b011,
        WDK_REG_STATUS = 3'b100
    } wdk_reg_t;

endpackage : wdk_pkg

// ==== verilog/wdk_counter.sv ====
// watchdog time-out counter stepped by the low-speed oscillator tick
`timescale 1ns/1ps
module wdk_counter (
    input  wire logic        sys_clk,   // system clock
    input  wire logic        sys_rst,   // synchronous reset
    input  wire logic        tick,      // low-speed oscillator enable
    input  wire logic        run,       // counting enabled
    input  wire logic        clear,     // clear the count
    input  wire logic [2:0]  sel,       // time-out select
    output logic             overflow,  // one-cycle time-out pulse
    output logic [18:0]      count      // current count
);

    function automatic logic [18:0] wdk_limit(input logic [2:0] s);
        case (s)
            3'h0:    wdk_limit = 19'h00100;
            3'h1:    wdk_limit = 19'h00400;
            3'h2:    wdk_limit = 19'h01000;
            3'h3:    wdk_limit = 19'h04000;
            3'h4:    wdk_limit = 19'h08000;
            3'h5:    wdk_limit = 19'h10000;
            3'h6:    wdk_limit = 19'h20000;
            default: wdk_limit = 19'h40000;
        endcase
    endfunction : wdk_limit

    logic hit;
    assign hit = tick && run && (count == wdk_limit(sel) - 19'h00001); // [RULE2] [RULE20]

    always_ff @(posedge sys_clk) begin
        if (sys_rst || clear) begin
            count <= 19'h00000; // [RULE8]
        end else if (hit) begin
            count <= 19'h00000;
        end else if (tick && run) begin
            count <= count + 19'h00001; // [RULE1]
        end
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            overflow <= 1'b0;
        end else begin
            overflow <= hit && !clear;
        end
    end

    property p_count_clear;
        @(posedge sys_clk) disable iff (sys_rst) clear |=> count == 19'h00000;
    endproperty
    a_count_clear: assert property (p_count_clear) else $error("count not cleared"); // [RULE8]

    property p_hold_when_stopped;
        @(posedge sys_clk) disable iff (sys_rst) (!run && !clear) |=> $stable(count);
    endproperty
    a_hold_when_stopped: assert property (p_hold_when_stopped) else $error("count moved while off"); // [RULE3]

endmodule : wdk_counter

// ==== dv/tb_wdk_top.sv ====
// self-checking testbench for the watchdog block and its time-out counter
`timescale 1ns/1ps
`include "wdk_params.svh"
module tb_wdk_top;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] data;
        logic       fire;
        logic [7:0] flags;
    } wdk_tb_row_t;

    logic        sys_clk         = 1'b0;
    logic        sys_rst         = 1'b1;
    logic [3:0]  address         = 4'h0;
    logic        read            = 1'b0;
    logic        write           = 1'b0;
    logic [31:0] writedata       = 32'h0;
    logic [3:0]  byteenable      = 4'hf;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        clear_wdt_instr = 1'b0;
    logic        stop_instr      = 1'b0;
    logic        sleep_mode      = 1'b0;
    logic        device_reset;
    logic        pc_sp_reset;
    logic        pc_clear;
    logic        port_preset;
    logic        expiry_flag;
    logic        powerdown_flag;
    int          n_errors        = 0;
    int          num_checks      = 0;
    logic [31:0] q;
    int          n;

    localparam wdk_tb_row_t ROWS [8] = '{
        '{`WDK_OFS_CTRL, 8'hab, 1'b0, 8'h00}, '{`WDK_OFS_CTRL, 8'h53, 1'b0, 8'h00},
        '{`WDK_OFS_RKEY, 8'h55, 1'b0, 8'h00}, '{`WDK_OFS_RKEY, 8'haa, 1'b0, 8'h00},
        '{`WDK_OFS_CTRL, 8'h03, 1'b1, 8'h01}, '{`WDK_OFS_CTRL, 8'hfb, 1'b1, 8'h01},
        '{`WDK_OFS_RKEY, 8'h00, 1'b1, 8'h08}, '{`WDK_OFS_RKEY, 8'h56, 1'b1, 8'h08}};

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    wdk_top dut_u (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest),
        .clear_wdt_instr(clear_wdt_instr), .stop_instr(stop_instr),
        .sleep_mode(sleep_mode), .device_reset(device_reset), .pc_sp_reset(pc_sp_reset),
        .pc_clear(pc_clear), .port_preset(port_preset), .expiry_flag(expiry_flag),
        .powerdown_flag(powerdown_flag));

    task automatic print_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // one avalon transfer; held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d,
                       input logic [3:0] be, output logic [31:0] rd);
        int i;
        @(posedge sys_clk);
        address    <= a;
        writedata  <= {24'h0, d};
        byteenable <= be;
        write      <= wr;
        read       <= ~wr;
        for (i = 0; i < 20; i++) begin
            @(posedge sys_clk);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        write <= 1'b0;
        read  <= 1'b0;
        if (i == 20) begin
            n_errors++;
            print_verdict();
        end
    endtask : bus

    // edges until device_reset shows high, zero if none within the bound
    task automatic wait_fire(input int lim, output int k);
        for (k = 1; k <= lim; k++) begin
            @(posedge sys_clk);
            #1;
            if (device_reset === 1'b1) return;
        end
        k = 0;
    endtask : wait_fire

    task automatic do_reset(input int cyc);
        @(posedge sys_clk);
        sys_rst <= 1'b1;
        repeat (cyc) @(posedge sys_clk);
        #1;
        check(pc_clear, 1'b1);
        check(port_preset, 1'b1);
        check({device_reset, pc_sp_reset}, 2'b00);
        check({expiry_flag, powerdown_flag}, 2'b00);
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        #1;
        check({pc_clear, port_preset}, 2'b00);
        bus(1'b0, `WDK_OFS_CTRL, 8'h0, 4'hf, q);
        check(q, `WDK_CTRL_POR);
        bus(1'b0, `WDK_OFS_RKEY, 8'h0, 4'hf, q);
        check(q, `WDK_RKEY_POR);
    endtask : do_reset

    initial begin
        do_reset(16);
        bus(1'b0, `WDK_OFS_FLAGS, 8'h0, 4'hf, q);
        check(q, 32'h0);
        foreach (ROWS[r]) begin
            bus(1'b1, ROWS[r].addr, ROWS[r].data, 4'hf, q);
            wait_fire(40, n);
            if (ROWS[r].fire) begin
                check(n, 18);
                check({pc_clear, port_preset, pc_sp_reset}, 3'b110);
                @(posedge sys_clk);
                #1;
                check(device_reset, 1'b0);
                bus(1'b1, `WDK_OFS_FLAGS, 8'hff, 4'hf, q);
                bus(1'b0, `WDK_OFS_FLAGS, 8'h0, 4'hf, q);
                check(q, {24'h0, ROWS[r].flags});
                bus(1'b0, `WDK_OFS_CTRL, 8'h0, 4'hf, q);
                check(q, `WDK_CTRL_POR);
                bus(1'b0, `WDK_OFS_RKEY, 8'h0, 4'hf, q);
                check(q, `WDK_RKEY_POR);
                bus(1'b1, `WDK_OFS_FLAGS, 8'h00, 4'hf, q);
                bus(1'b0, `WDK_OFS_FLAGS, 8'h0, 4'hf, q);
                check(q, 32'h0);
            end else begin
                check(n, 0);
                bus(1'b0, ROWS[r].addr, 8'h0, 4'hf, q);
                check(q, {24'h0, ROWS[r].data});
            end
        end
        // lane 0 disabled and unmapped place: nothing changes
        bus(1'b1, `WDK_OFS_CTRL, 8'h03, 4'he, q);
        wait_fire(30, n);
        check(n, 0);
        bus(1'b1, 4'h2, 8'h03, 4'hf, q);
        bus(1'b0, 4'h2, 8'h0, 4'hf, q);
        check(q, 32'h0);
        bus(1'b0, `WDK_OFS_CTRL, 8'h0, 4'hf, q);
        check(q, `WDK_CTRL_POR);
        // stop instruction with the core asleep, then clear instruction with the core awake
        @(posedge sys_clk);
        sleep_mode <= 1'b1;
        stop_instr <= 1'b1;
        @(posedge sys_clk);
        stop_instr <= 1'b0;
        #1;
        check({expiry_flag, powerdown_flag}, 2'b01);
        bus(1'b1, `WDK_OFS_STATUS, 8'h00, 4'hf, q);
        bus(1'b0, `WDK_OFS_STATUS, 8'h0, 4'hf, q);
        check(q, 32'h2);
        @(posedge sys_clk);
        sleep_mode      <= 1'b0;
        clear_wdt_instr <= 1'b1;
        @(posedge sys_clk);
        clear_wdt_instr <= 1'b0;
        #1;
        check(powerdown_flag, 1'b0);
        // second reset in mid-run restores the keys
        bus(1'b1, `WDK_OFS_CTRL, 8'hab, 4'hf, q);
        do_reset(2);
        // time-out count seen through the top: one step per low-speed tick
        @(posedge sys_clk);
        clear_wdt_instr <= 1'b1;
        @(posedge sys_clk);
        clear_wdt_instr <= 1'b0;
        #1;
        check(dut_u.wdt_count, 19'h0);
        for (int t = 1; t <= 4; t++) begin
            repeat (`WDK_LSO_DIV) @(posedge sys_clk);
            #1;
            check(dut_u.wdt_count, t);
        end
        // stop clears the count, which resumes while enabled
        @(posedge sys_clk);
        stop_instr <= 1'b1;
        @(posedge sys_clk);
        stop_instr <= 1'b0;
        #1;
        check(dut_u.wdt_count, 19'h0);
        repeat (`WDK_LSO_DIV) @(posedge sys_clk);
        #1;
        check(dut_u.wdt_count, 19'h1);
        // disabled, then stop: the count stays cleared
        bus(1'b1, `WDK_OFS_CTRL, 8'hab, 4'hf, q);
        @(posedge sys_clk);
        stop_instr <= 1'b1;
        @(posedge sys_clk);
        stop_instr <= 1'b0;
        repeat (2 * `WDK_LSO_DIV) @(posedge sys_clk);
        #1;
        check(dut_u.wdt_count, 19'h0);
        print_verdict();
    end
endmodule : tb_wdk_top
